//--- rtl/fxu_map.svh
// Register offsets, field positions, reset values and encodings
`ifndef FXU_MAP_SVH
`define FXU_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define FXU_OFS_STK_STATUS 8'h00
`define FXU_OFS_STK_CTRL 8'h04
`define FXU_OFS_SIMD_CSR 8'h08
`define FXU_OFS_TRAP_INFO 8'h0C

// ****************************************************************
// Field positions
// ****************************************************************
`define FXU_FLAG_LSB 0
`define FXU_STK_MASK_LSB 0
`define FXU_STK_RC_LSB 10
`define FXU_SIMD_MASK_LSB 7
`define FXU_SIMD_RC_LSB 13
`define FXU_TRAP_UNIT_BIT 8
`define FXU_TRAP_PEND_BIT 9

// ****************************************************************
// Reset values
// ****************************************************************
`define FXU_FLAG_RST 6'h00
`define FXU_MASK_RST 6'h3F
`define FXU_RC_RST 2'h0

// ****************************************************************
// Single precision encodings
// ****************************************************************
`define FXU_QNAN_INDEF 32'hFFC00000
`define FXU_INT_INDEF 32'h80000000
`define FXU_EXP_ALL_ONES 8'hFF
`define FXU_EXP_MAX_FINITE 8'hFE
`define FXU_FRAC_ALL_ONES 23'h7FFFFF
`define FXU_QUIET_BIT 22
`define FXU_EXP_OVF_LIMIT 10'h0FF

`endif

//--- rtl/fxu_pkg.sv
// Types shared by the floating-point exception unit
`default_nettype none
package fxu_pkg;

	typedef enum logic [1:0] {
		RC_NEAREST = 2'h0,
		RC_DOWN = 2'h1,
		RC_UP = 2'h2,
		RC_TRUNC = 2'h3
	} fxu_rc_t;

	typedef enum logic {
		UNIT_STACK = 1'b0,
		UNIT_SIMD = 1'b1
	} fxu_unit_t;

	typedef enum logic [2:0] {
		OP_ADD = 3'h0,
		OP_SUB = 3'h1,
		OP_MUL = 3'h2,
		OP_DIV = 3'h3,
		OP_CVT = 3'h4,
		OP_CVTT = 3'h5
	} fxu_op_t;

	typedef enum logic [1:0] {
		ACT_PROCEED = 2'h0,
		ACT_DEFAULT = 2'h1,
		ACT_SUPPRESS = 2'h2
	} fxu_act_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_TRAP = 2'b10
	} fxu_state_t;

	typedef enum logic [1:0] {
		RES_FLOAT = 2'h0,
		RES_INT = 2'h1,
		RES_INT_TRUNC = 2'h2
	} fxu_res_kind_t;

	// Bit 0 upward: invalid, subnormal, zdiv, ovf, unf, inexact
	typedef struct packed {
		logic inexact;
		logic unf;
		logic ovf;
		logic zdiv;
		logic subnorm_op;
		logic invalid_op;
	} fxu_exc_t;

	typedef struct packed {
		logic sign;
		logic zero;
		logic subnorm;
		logic inf;
		logic nan;
		logic snan;
	} fxu_class_t;

	typedef struct packed {
		fxu_unit_t unit;
		fxu_op_t op;
		logic [31:0] a;
		logic [31:0] b;
	} fxu_pre_req_t;

	typedef struct packed {
		fxu_unit_t unit;
		fxu_res_kind_t kind;
		logic sign;
		logic signed [9:0] exp;
		logic [31:0] mag;
		logic guard;
		logic sticky;
	} fxu_post_req_t;

endpackage
`default_nettype wire

//--- rtl/fxu_classify.sv
// Single precision operand classifier
`timescale 1ns/1ps
`default_nettype none
`include "fxu_map.svh"

module fxu_classify
(
	input wire logic [31:0] value,
	output fxu_pkg::fxu_class_t cls
);

	logic exp_ones;
	logic exp_zero;
	logic frac_zero;

	assign exp_ones = (value[30:23] == `FXU_EXP_ALL_ONES);
	assign exp_zero = (value[30:23] == 8'h00);
	assign frac_zero = (value[22:0] == 23'h000000);

	assign cls.sign = value[31];
	assign cls.zero = exp_zero & frac_zero;
	assign cls.subnorm = exp_zero & !frac_zero;
	assign cls.inf = exp_ones & frac_zero;
	assign cls.nan = exp_ones & !frac_zero;
	// Signalling NaN has the quiet bit clear
	assign cls.snan = exp_ones & !frac_zero & !value[`FXU_QUIET_BIT];

endmodule
`default_nettype wire

//--- rtl/fxu_top.sv
// Floating-point exception detection, flags, masks and responses
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fxu_map.svh"

// ****************************************************************
// Function
// - Truncating conversions always round toward zero
// - Six exception classes are recognised
// - Invalid, zdiv, subnormal checked on operands
// - Ovf, unf, inexact checked on result
// - Flag first; masked gives default, else handler
// - Flags sticky until software clears them
// - Stack flags and masks in bits 0-5
// - SIMD flags bits 0-5, masks 7-12
// - Each unit uses only its own set
// - Masked response continues; several flags possible
// - Masked invalid writes indefinite quiet NaN, integer indefinite for conversions
// - Unmasked invalid: flag, handler, operands kept
// - Masked subnormal operand: flag, proceed normally
// - Unmasked subnormal: flag, handler, operands kept
// - Finite non-zero divided by zero raises zdiv
// - Masked zdiv returns infinity, xor sign
// - Unmasked zdiv: flag, handler, operands kept
// - Two-bit rounding field selects rounding mode
// - Any rounded result sets inexact flag
// ****************************************************************

module fxu_top
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output var logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic pre_valid,
	input wire fxu_pkg::fxu_pre_req_t pre_req,
	output logic pre_ready,
	output var logic pre_done,
	output var fxu_pkg::fxu_act_t pre_act,
	output var logic [31:0] pre_result,
	input wire logic post_valid,
	input wire fxu_pkg::fxu_post_req_t post_req,
	output logic post_ready,
	output var logic post_done,
	output var logic post_wr_en,
	output var logic [31:0] post_result,
	output logic trap_req,
	output var fxu_pkg::fxu_unit_t trap_unit,
	output var fxu_pkg::fxu_exc_t trap_cause,
	input wire logic trap_ack
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic round_inc(input fxu_pkg::fxu_rc_t rc,
		input logic sign, input logic lsb, input logic guard,
		input logic sticky);
		logic inc;
		inc = 1'b0;
		case (rc)
			fxu_pkg::RC_NEAREST: inc = guard & (sticky | lsb);
			fxu_pkg::RC_DOWN: inc = sign & (guard | sticky);
			fxu_pkg::RC_UP: inc = !sign & (guard | sticky);
			fxu_pkg::RC_TRUNC: inc = 1'b0;
			default: inc = 1'b0;
		endcase
		return inc;
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	fxu_pkg::fxu_exc_t stk_flag;
	fxu_pkg::fxu_exc_t stk_mask;
	fxu_pkg::fxu_rc_t stk_rc;
	fxu_pkg::fxu_exc_t simd_flag;
	fxu_pkg::fxu_exc_t simd_mask;
	fxu_pkg::fxu_rc_t simd_rc;
	fxu_pkg::fxu_exc_t next_stk_flag;
	fxu_pkg::fxu_exc_t next_stk_mask;
	fxu_pkg::fxu_rc_t next_stk_rc;
	fxu_pkg::fxu_exc_t next_simd_flag;
	fxu_pkg::fxu_exc_t next_simd_mask;
	fxu_pkg::fxu_rc_t next_simd_rc;
	fxu_pkg::fxu_state_t state;
	logic wr_pend;
	logic [7:0] wr_addr;
	logic addr_phase;
	logic [31:0] rd_word;

	fxu_pkg::fxu_class_t cls_a;
	fxu_pkg::fxu_class_t cls_b;
	fxu_pkg::fxu_exc_t pre_flags;
	fxu_pkg::fxu_exc_t pre_mask;
	fxu_pkg::fxu_exc_t pre_trap;
	fxu_pkg::fxu_act_t pre_next_act;
	logic [31:0] pre_next_result;
	logic pre_fire;

	fxu_pkg::fxu_exc_t post_flags;
	fxu_pkg::fxu_exc_t post_mask;
	fxu_pkg::fxu_exc_t post_trap;
	fxu_pkg::fxu_rc_t post_rc;
	logic [31:0] post_next_result;
	logic post_next_wr;
	logic post_fire;

	fxu_pkg::fxu_exc_t stk_set;
	fxu_pkg::fxu_exc_t simd_set;

	// ****************************************************************
	// Bus slave
	// ****************************************************************
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_phase = hsel & hready & htrans[1];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end
		else
		begin
			wr_pend <= addr_phase & hwrite;
			wr_addr <= haddr[7:0];
		end
	end

	// Read from next values so a read right after a write sees it
	always_comb
	begin
		rd_word = 32'h00000000;
		case (haddr[7:0])
			`FXU_OFS_STK_STATUS: rd_word[5:0] = next_stk_flag;
			`FXU_OFS_STK_CTRL:
			begin
				rd_word[`FXU_STK_MASK_LSB +: 6] = next_stk_mask;
				rd_word[`FXU_STK_RC_LSB +: 2] = next_stk_rc;
			end
			`FXU_OFS_SIMD_CSR:
			begin
				rd_word[`FXU_FLAG_LSB +: 6] = next_simd_flag;
				rd_word[`FXU_SIMD_MASK_LSB +: 6] = next_simd_mask;
				rd_word[`FXU_SIMD_RC_LSB +: 2] = next_simd_rc;
			end
			`FXU_OFS_TRAP_INFO:
			begin
				rd_word[5:0] = trap_cause;
				rd_word[`FXU_TRAP_UNIT_BIT] = trap_unit;
				rd_word[`FXU_TRAP_PEND_BIT] = (state == fxu_pkg::ST_TRAP);
			end
			default: rd_word = 32'h00000000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (addr_phase & !hwrite)
			hrdata <= rd_word;
	end

	// ****************************************************************
	// Control and status registers
	// ****************************************************************
	// Hardware set wins over a software clear in the same cycle
	always_comb
	begin
		next_stk_flag = stk_flag;
		next_stk_mask = stk_mask;
		next_stk_rc = stk_rc;
		next_simd_flag = simd_flag;
		next_simd_mask = simd_mask;
		next_simd_rc = simd_rc;
		if (wr_pend && wr_addr == `FXU_OFS_STK_STATUS)
			next_stk_flag = hwdata[`FXU_FLAG_LSB +: 6];
		if (wr_pend && wr_addr == `FXU_OFS_STK_CTRL)
		begin
			next_stk_mask = hwdata[`FXU_STK_MASK_LSB +: 6];
			next_stk_rc = fxu_pkg::fxu_rc_t'(hwdata[`FXU_STK_RC_LSB +: 2]);
		end
		if (wr_pend && wr_addr == `FXU_OFS_SIMD_CSR)
		begin
			next_simd_flag = hwdata[`FXU_FLAG_LSB +: 6];
			next_simd_mask = hwdata[`FXU_SIMD_MASK_LSB +: 6];
			next_simd_rc = fxu_pkg::fxu_rc_t'(hwdata[`FXU_SIMD_RC_LSB +: 2]);
		end
		next_stk_flag = next_stk_flag | stk_set;
		next_simd_flag = next_simd_flag | simd_set;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			stk_flag <= `FXU_FLAG_RST;
			stk_mask <= `FXU_MASK_RST;
			stk_rc <= fxu_pkg::RC_NEAREST;
			simd_flag <= `FXU_FLAG_RST;
			simd_mask <= `FXU_MASK_RST;
			simd_rc <= fxu_pkg::RC_NEAREST;
		end
		else
		begin
			stk_flag <= next_stk_flag;
			stk_mask <= next_stk_mask;
			stk_rc <= next_stk_rc;
			simd_flag <= next_simd_flag;
			simd_mask <= next_simd_mask;
			simd_rc <= next_simd_rc;
		end
	end

	// Each unit's events land only in that unit's flags
	assign stk_set = ((pre_fire && pre_req.unit == fxu_pkg::UNIT_STACK) ?
		pre_flags : 6'h00) | ((post_fire &&
		post_req.unit == fxu_pkg::UNIT_STACK) ? post_flags : 6'h00);
	assign simd_set = ((pre_fire && pre_req.unit == fxu_pkg::UNIT_SIMD) ?
		pre_flags : 6'h00) | ((post_fire &&
		post_req.unit == fxu_pkg::UNIT_SIMD) ? post_flags : 6'h00);

	// ****************************************************************
	// Operand checks
	// ****************************************************************
	fxu_classify u_cls_a
	(
		.value(pre_req.a),
		.cls(cls_a)
	);

	fxu_classify u_cls_b
	(
		.value(pre_req.b),
		.cls(cls_b)
	);

	assign pre_ready = (state == fxu_pkg::ST_IDLE);
	assign post_ready = (state == fxu_pkg::ST_IDLE);
	assign pre_fire = pre_valid & pre_ready;
	assign post_fire = post_valid & post_ready;
	assign pre_mask = (pre_req.unit == fxu_pkg::UNIT_SIMD) ?
		simd_mask : stk_mask;

	always_comb
	begin
		logic cvt;
		logic sub_eff;
		cvt = (pre_req.op == fxu_pkg::OP_CVT) ||
			(pre_req.op == fxu_pkg::OP_CVTT);
		sub_eff = cls_a.sign ^ cls_b.sign ^ (pre_req.op == fxu_pkg::OP_SUB);
		pre_flags = 6'h00;
		// Detected before any arithmetic happens
		if (cvt)
		begin
			pre_flags.invalid_op = cls_a.nan | cls_a.inf;
			pre_flags.subnorm_op = cls_a.subnorm;
		end
		else
		begin
			pre_flags.subnorm_op = cls_a.subnorm | cls_b.subnorm;
			case (pre_req.op)
				fxu_pkg::OP_ADD, fxu_pkg::OP_SUB:
					pre_flags.invalid_op = cls_a.inf & cls_b.inf & sub_eff;
				fxu_pkg::OP_MUL:
					pre_flags.invalid_op = (cls_a.inf & cls_b.zero) |
						(cls_a.zero & cls_b.inf);
				fxu_pkg::OP_DIV:
					pre_flags.invalid_op = (cls_a.inf & cls_b.inf) |
						(cls_a.zero & cls_b.zero);
				default: pre_flags.invalid_op = 1'b0;
			endcase
			pre_flags.invalid_op = pre_flags.invalid_op |
				cls_a.snan | cls_b.snan;
			pre_flags.zdiv = (pre_req.op == fxu_pkg::OP_DIV) & cls_b.zero &
				!cls_a.zero & !cls_a.inf & !cls_a.nan;
		end
	end

	assign pre_trap = pre_flags & ~pre_mask;

	always_comb
	begin
		pre_next_act = fxu_pkg::ACT_PROCEED;
		pre_next_result = 32'h00000000;
		if (|pre_trap)
			pre_next_act = fxu_pkg::ACT_SUPPRESS;
		else if (pre_flags.invalid_op)
		begin
			pre_next_act = fxu_pkg::ACT_DEFAULT;
			pre_next_result = (pre_req.op == fxu_pkg::OP_CVT ||
				pre_req.op == fxu_pkg::OP_CVTT) ?
				`FXU_INT_INDEF : `FXU_QNAN_INDEF;
		end
		else if (pre_flags.zdiv)
		begin
			pre_next_act = fxu_pkg::ACT_DEFAULT;
			pre_next_result = {cls_a.sign ^ cls_b.sign,
				`FXU_EXP_ALL_ONES, 23'h000000};
		end
		else if (cls_a.nan || cls_b.nan)
		begin
			// Quiet NaN operands propagate without a flag
			pre_next_act = fxu_pkg::ACT_DEFAULT;
			pre_next_result = cls_a.nan ? pre_req.a : pre_req.b;
		end
		else
			pre_next_act = fxu_pkg::ACT_PROCEED;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pre_done <= 1'b0;
			pre_act <= fxu_pkg::ACT_PROCEED;
			pre_result <= 32'h00000000;
		end
		else
		begin
			pre_done <= pre_fire;
			if (pre_fire)
			begin
				pre_act <= pre_next_act;
				pre_result <= pre_next_result;
			end
		end
	end

	// ****************************************************************
	// Result checks and rounding
	// ****************************************************************
	assign post_mask = (post_req.unit == fxu_pkg::UNIT_SIMD) ?
		simd_mask : stk_mask;

	always_comb
	begin
		logic inc;
		logic inexact;
		logic tiny;
		logic inf_ok;
		logic [24:0] sum25;
		logic [32:0] sum33;
		logic signed [9:0] exp_r;
		logic [22:0] frac_r;
		tiny = 1'b0;
		post_rc = (post_req.unit == fxu_pkg::UNIT_SIMD) ? simd_rc : stk_rc;
		if (post_req.kind == fxu_pkg::RES_INT_TRUNC)
			post_rc = fxu_pkg::RC_TRUNC;
		inc = round_inc(post_rc, post_req.sign, post_req.mag[0],
			post_req.guard, post_req.sticky);
		inexact = post_req.guard | post_req.sticky;
		sum25 = {1'b0, post_req.mag[23:0]} + {24'h000000, inc};
		sum33 = {1'b0, post_req.mag} + {32'h00000000, inc};
		exp_r = post_req.exp + {9'h000, sum25[24]};
		frac_r = sum25[24] ? sum25[23:1] : sum25[22:0];
		inf_ok = (post_rc == fxu_pkg::RC_NEAREST) ||
			(post_rc == fxu_pkg::RC_DOWN && post_req.sign) ||
			(post_rc == fxu_pkg::RC_UP && !post_req.sign);
		post_flags = 6'h00;
		post_next_result = 32'h00000000;
		if (post_req.kind == fxu_pkg::RES_FLOAT)
		begin
			// Checked on the computed result
			tiny = (post_req.exp <= 10'sd0) && (post_req.mag != 32'h0);
			post_flags.ovf = (exp_r >= $signed(`FXU_EXP_OVF_LIMIT));
			post_flags.unf = tiny & (inexact | !post_mask.unf);
			post_flags.inexact = inexact | post_flags.ovf;
			if (post_flags.ovf)
				post_next_result = inf_ok ?
					{post_req.sign, `FXU_EXP_ALL_ONES, 23'h000000} :
					{post_req.sign, `FXU_EXP_MAX_FINITE, `FXU_FRAC_ALL_ONES};
			else if (tiny)
				post_next_result = {post_req.sign, 31'h00000000};
			else
				post_next_result = {post_req.sign, exp_r[7:0], frac_r};
		end
		else
		begin
			tiny = 1'b0;
			post_flags.invalid_op = sum33[32] | (sum33[31] &
				!(post_req.sign && sum33[30:0] == 31'h00000000));
			post_flags.inexact = inexact & !post_flags.invalid_op;
			post_next_result = post_flags.invalid_op ? `FXU_INT_INDEF :
				(post_req.sign ? (32'h0 - sum33[31:0]) : sum33[31:0]);
		end
	end

	assign post_trap = post_flags & ~post_mask;
	// Unmasked inexact alone still stores the rounded result
	assign post_next_wr = !(post_trap.invalid_op | post_trap.ovf |
		post_trap.unf);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			post_done <= 1'b0;
			post_wr_en <= 1'b0;
			post_result <= 32'h00000000;
		end
		else
		begin
			post_done <= post_fire;
			post_wr_en <= post_fire & post_next_wr;
			if (post_fire)
				post_result <= post_next_result;
		end
	end

	// ****************************************************************
	// Handler request
	// ****************************************************************
	// Held until acknowledged; both stages stall meanwhile
	assign trap_req = (state == fxu_pkg::ST_TRAP);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state <= fxu_pkg::ST_IDLE;
			trap_unit <= fxu_pkg::UNIT_STACK;
			trap_cause <= 6'h00;
		end
		else
		begin
			case (state)
				fxu_pkg::ST_IDLE:
				begin
					if ((post_fire && |post_trap) || (pre_fire && |pre_trap))
					begin
						state <= fxu_pkg::ST_TRAP;
						trap_cause <= (post_fire ? post_trap : 6'h00) |
							(pre_fire ? pre_trap : 6'h00);
						trap_unit <= (post_fire && |post_trap) ?
							post_req.unit : pre_req.unit;
					end
				end
				fxu_pkg::ST_TRAP:
				begin
					if (trap_ack)
						state <= fxu_pkg::ST_IDLE;
				end
				default: state <= fxu_pkg::ST_IDLE;
			endcase
		end
	end

endmodule
`default_nettype wire

//--- verification/fxu_top_monitor.sv
// Checker of handshake and trap behaviour at the unit's ports
`timescale 1ns/1ps
`default_nettype none
module fxu_top_monitor
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic pre_valid,
	input wire logic pre_ready,
	input wire logic pre_done,
	input wire fxu_pkg::fxu_act_t pre_act,
	input wire logic post_valid,
	input wire logic post_ready,
	input wire logic post_done,
	input wire logic post_wr_en,
	input wire logic trap_req,
	input wire fxu_pkg::fxu_exc_t trap_cause,
	input wire logic trap_ack
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	a_pre_answer: assert property (
		pre_valid && pre_ready |=> pre_done) else $error("pre not answered");
	a_pre_cause: assert property (
		pre_done |-> $past(pre_valid && pre_ready)) else $error("stray pre done");
	a_post_answer: assert property (
		post_valid && post_ready |=> post_done) else $error("post not answered");
	a_wr_with_done: assert property (
		post_wr_en |-> post_done) else $error("write without done");
	a_trap_holds: assert property (
		trap_req && !trap_ack |=> trap_req && $stable(trap_cause))
		else $error("trap request unstable");
	a_trap_release: assert property (
		trap_req && trap_ack |=> !trap_req) else $error("trap not released");
	a_busy_refuse: assert property (
		trap_req |-> !pre_ready && !post_ready) else $error("taken while busy");
	a_suppress_trap: assert property (
		pre_done && pre_act == fxu_pkg::ACT_SUPPRESS |-> trap_req
		&& trap_cause != 6'h00) else $error("suppress without trap");
	a_trap_source: assert property (
		$rose(trap_req) |-> pre_done || post_done) else $error("trap from nowhere");
endmodule
bind fxu_top fxu_top_monitor u_fxu_top_monitor (.hclk(hclk), .hresetn(hresetn),
	.pre_valid(pre_valid), .pre_ready(pre_ready), .pre_done(pre_done),
	.pre_act(pre_act), .post_valid(post_valid), .post_ready(post_ready),
	.post_done(post_done), .post_wr_en(post_wr_en), .trap_req(trap_req),
	.trap_cause(trap_cause), .trap_ack(trap_ack));
`default_nettype wire

//--- verification/fxu_handler_model.sv
// Behavioural software handler that acknowledges a trap request
`timescale 1ns/1ps
`default_nettype none
module fxu_handler_model
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic trap_req,
	input wire logic [3:0] ack_delay,
	output var logic trap_ack
);
	logic [3:0] wait_cnt;
	// Ack is one pulse; held longer it could swallow a later trap
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wait_cnt <= 4'h0;
			trap_ack <= 1'b0;
		end
		else if (trap_req && !trap_ack)
		begin
			trap_ack <= (wait_cnt >= ack_delay);
			wait_cnt <= wait_cnt + 4'h1;
		end
		else
		begin
			trap_ack <= 1'b0;
			wait_cnt <= 4'h0;
		end
	end
endmodule
`default_nettype wire

//--- verification/fxu_top_tb.sv
// Self-checking bench of the floating-point exception unit
`timescale 1ns/1ps
`default_nettype none
module fxu_top_tb;
	logic hclk, hresetn, hsel, hwrite, pre_valid, post_valid;
	logic [31:0] haddr, hwdata, hrdata, pre_result, post_result;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp, pre_ready, pre_done, post_ready, post_done;
	logic post_wr_en, trap_req, trap_ack;
	logic [3:0] ack_delay;
	fxu_pkg::fxu_pre_req_t pre_req;
	fxu_pkg::fxu_post_req_t post_req;
	fxu_pkg::fxu_act_t pre_act;
	fxu_pkg::fxu_unit_t trap_unit;
	fxu_pkg::fxu_exc_t trap_cause;
	int fail_count, comparisons;
	fxu_top u_fxu_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pre_valid(pre_valid),
		.pre_req(pre_req), .pre_ready(pre_ready), .pre_done(pre_done),
		.pre_act(pre_act), .pre_result(pre_result), .post_valid(post_valid),
		.post_req(post_req), .post_ready(post_ready), .post_done(post_done),
		.post_wr_en(post_wr_en), .post_result(post_result),
		.trap_req(trap_req), .trap_unit(trap_unit), .trap_cause(trap_cause),
		.trap_ack(trap_ack));
	fxu_handler_model u_fxu_handler_model (.hclk(hclk), .hresetn(hresetn),
		.trap_req(trap_req), .ack_delay(ack_delay), .trap_ack(trap_ack));
	// ****************************************************************
	// Reporting and bus tasks
	// ****************************************************************
	task final_report;
		if (fail_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input string m, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			$display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
			fail_count++;
		end
	endtask
	task automatic step;
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
			if (n > 50)
			begin
				fail_count++;
				final_report;
			end
		end while (hreadyout !== 1'b1);
	endtask
	task ahb_wr(input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= 1'b1;
		step;
		htrans <= 2'h0;
		hwdata <= d;
		step;
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= 1'b0;
		step;
		htrans <= 2'h0;
		step;
		chk("register read", hrdata, exp);
		chk("bus okay", {31'h0, hresp}, 32'h0);
	endtask
	task automatic accept(input bit p);
		int n;
		n = 0;
		do
		begin
			@(negedge hclk);
			n++;
			if (n > 50)
			begin
				fail_count++;
				final_report;
			end
		end while ((p ? post_ready : pre_ready) !== 1'b1);
		@(posedge hclk);
		pre_valid <= 1'b0;
		post_valid <= 1'b0;
		@(negedge hclk);
	endtask
	task pre_go(input fxu_pkg::fxu_unit_t u, input fxu_pkg::fxu_op_t o,
		input logic [31:0] a, input logic [31:0] b, input logic [1:0] act,
		input logic [31:0] res);
		@(posedge hclk);
		pre_valid <= 1'b1;
		pre_req <= '{unit: u, op: o, a: a, b: b};
		accept(1'b0);
		chk("pre done", {31'h0, pre_done}, 32'h1);
		chk("pre action", {30'h0, pre_act}, {30'h0, act});
		if (act == 2'h1)
			chk("pre result", pre_result, res);
		@(posedge hclk);
	endtask
	task post_go(input fxu_pkg::fxu_res_kind_t k, input logic [31:0] res);
		@(posedge hclk);
		post_valid <= 1'b1;
		post_req <= '{unit: fxu_pkg::UNIT_STACK, kind: k, sign: 1'b0,
			exp: 10'sh000, mag: 32'h00000005, guard: 1'b1, sticky: 1'b1};
		accept(1'b1);
		chk("post write", {30'h0, post_done, post_wr_en}, 32'h3);
		chk("post result", post_result, res);
		@(posedge hclk);
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task s_reset_map;
		rd_chk(8'h00, 32'h00000000);
		rd_chk(8'h04, 32'h0000003F);
		rd_chk(8'h08, 32'h00001F80);
		ahb_wr(8'h40, 32'hFFFFFFFF);
		rd_chk(8'h40, 32'h00000000);
	endtask
	task s_masked_stack;
		pre_go(fxu_pkg::UNIT_STACK, fxu_pkg::OP_DIV, 32'h3F800000,
			32'h80000000, 2'h1, 32'hFF800000);
		rd_chk(8'h00, 32'h00000004);
		pre_go(fxu_pkg::UNIT_STACK, fxu_pkg::OP_DIV, 32'h00000000,
			32'h00000000, 2'h1, 32'hFFC00000);
		rd_chk(8'h00, 32'h00000005);
		rd_chk(8'h08, 32'h00001F80);
	endtask
	task s_subnorm_simd;
		pre_go(fxu_pkg::UNIT_SIMD, fxu_pkg::OP_ADD, 32'h00000001,
			32'h3F800000, 2'h0, 32'h0);
		rd_chk(8'h08, 32'h00001F82);
		rd_chk(8'h00, 32'h00000005);
	endtask
	task automatic s_unmasked_zdiv;
		int n;
		ack_delay <= 4'h3;
		ahb_wr(8'h08, 32'h00001D80);
		pre_go(fxu_pkg::UNIT_SIMD, fxu_pkg::OP_DIV, 32'h3F800000,
			32'h00000000, 2'h2, 32'h0);
		chk("trap", {24'h0, trap_req, trap_unit, trap_cause}, 32'hC4);
		n = 0;
		while (trap_req !== 1'b0 && n < 20)
		begin
			@(negedge hclk);
			n++;
		end
		chk("trap ends", {31'h0, trap_req}, 32'h0);
		if (n >= 20)
			final_report;
		rd_chk(8'h08, 32'h00001D84);
	endtask
	task s_truncate;
		ahb_wr(8'h04, 32'h0000083F);
		post_go(fxu_pkg::RES_INT_TRUNC, 32'h00000005);
		post_go(fxu_pkg::RES_INT, 32'h00000006);
		rd_chk(8'h00, 32'h00000025);
		// Tiny inexact float result: masked underflow gives zero
		post_go(fxu_pkg::RES_FLOAT, 32'h00000000);
		rd_chk(8'h00, 32'h00000035);
	endtask
	// ****************************************************************
	// Clock, reset and main sequence
	// ****************************************************************
	initial
	begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	initial
	begin
		fail_count = 0;
		comparisons = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		pre_valid = 1'b0;
		post_valid = 1'b0;
		pre_req = '0;
		post_req = '0;
		ack_delay = 4'h0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		s_reset_map;
		s_masked_stack;
		s_subnorm_simd;
		s_unmasked_zdiv;
		s_truncate;
		final_report;
	end
endmodule
`default_nettype wire
